// ---- common/dsc_defines.vh ----
// Register offsets, field positions and timing counts of the self-calibration and trim block.
`ifndef DSC_DEFINES_VH
`define DSC_DEFINES_VH
// ********************************************************
// Register offsets
// ********************************************************
`define DSC_I_FINE_GAIN      7'h03
`define DSC_I_COARSE_GAIN    7'h04
`define DSC_I_CM_TRIM        7'h05
`define DSC_Q_FINE_GAIN      7'h06
`define DSC_Q_COARSE_GAIN    7'h07
`define DSC_Q_CM_TRIM        7'h08
`define DSC_REF_TRIM         7'h0D
`define DSC_CAL_CLK_SEL      7'h0E
`define DSC_CAL_DONE_STAT    7'h0F
`define DSC_COEF_ADDR        7'h10
`define DSC_COEF_DATA        7'h11
`define DSC_CAL_CMD          7'h12
// ********************************************************
// Field positions
// ********************************************************
`define DSC_DIV_LSB          0
`define DSC_DIV_MSB          2
`define DSC_CLK_EN_BIT       3
`define DSC_I_SEL_BIT        4
`define DSC_Q_SEL_BIT        5
`define DSC_Q_UNCAL_BIT      0
`define DSC_I_UNCAL_BIT      1
`define DSC_RD_BIT           2
`define DSC_WR_BIT           3
`define DSC_START_BIT        4
`define DSC_I_DONE_BIT       6
`define DSC_Q_DONE_BIT       7
`define DSC_CM_EN_BIT        6
`define DSC_READ_FLAG_BIT    7
// ********************************************************
// Reset values and timing counts
// ********************************************************
`define DSC_REG_RESET        8'h00
`define DSC_COEF_FIRST       7'h01
`define DSC_PRESCALE         16
`define DSC_CAL_TICKS        300
`endif

// ---- design/dsc_cal_engine.v ----
// One calibration engine with its coefficient store, used once per DAC.
`timescale 1ns/1ps
`include "dsc_defines.vh"
module dsc_cal_engine #(
   parameter CAL_TICKS = `DSC_CAL_TICKS,
   parameter NCOEF     = 32
) (
   input  wire       sys_clk,
   input  wire       rst,
   input  wire       cal_tick,
   input  wire       start_level,
   input  wire       uncal_clear,
   input  wire [5:0] measure,
   input  wire [4:0] host_idx,
   input  wire       host_we,
   input  wire [5:0] host_wdata,
   output reg  [5:0] host_rdata,
   output reg        done_reg,
   output reg        uncal_reg,
   output reg        busy_reg
);
   reg [5:0] coef_mem [0:NCOEF-1];
   reg [8:0] tick_cnt_reg;
   reg       start_d_reg;
   wire      start_rise;
   wire      abort;
   wire      finish;

   assign start_rise = start_level & ~start_d_reg;
   assign abort      = busy_reg & ~start_level;
   assign finish     = busy_reg & start_level & cal_tick
                       & (tick_cnt_reg == CAL_TICKS[8:0] - 9'h001);

   // ********************************************************
   // Sequencing
   // ********************************************************
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         start_d_reg  <= 1'b0;
         busy_reg     <= 1'b0;
         done_reg     <= 1'b0;
         uncal_reg    <= 1'b1;
         tick_cnt_reg <= 9'h000;
      end
      else
      begin
         start_d_reg <= start_level;
         if (start_rise)
         begin
            busy_reg     <= 1'b1;
            done_reg     <= 1'b0;
            tick_cnt_reg <= 9'h000;
         end
         else if (abort)
            busy_reg <= 1'b0;
         else if (finish)
         begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end
         else if (busy_reg & cal_tick)
            tick_cnt_reg <= tick_cnt_reg + 9'h001;
         // An abort marks the DAC uncalibrated and wins over a clear.
         if (abort)
            uncal_reg <= 1'b1;
         else if (uncal_clear)
            uncal_reg <= 1'b0;
      end
   end

   // ********************************************************
   // Coefficient store
   // ********************************************************
   // The engine has priority; a host write that collides with a capture is lost.
   always @(posedge sys_clk)
   begin
      if (busy_reg & start_level & cal_tick & (tick_cnt_reg < NCOEF))
         coef_mem[tick_cnt_reg[4:0]] <= measure;
      else if (host_we)
         coef_mem[host_idx] <= host_wdata;
      host_rdata <= coef_mem[host_idx];
   end
endmodule // dsc_cal_engine

// ---- design/dsc_cal_trim.v ----
// Serial register port, calibration clock divider and trim registers of the dual DAC.
`timescale 1ns/1ps
`include "dsc_defines.vh"
module dsc_cal_trim #(
   parameter CAL_TICKS = `DSC_CAL_TICKS,
   parameter PRESCALE  = `DSC_PRESCALE
) (
   input  wire       sys_clk,
   input  wire       rst,
   input  wire       spi_sclk,
   input  wire       spi_cs_n,
   input  wire       spi_sdi,
   output reg        spi_sdo,
   output wire       spi_sdo_oe_n,
   input  wire [5:0] i_measure,
   input  wire [5:0] q_measure,
   output wire [5:0] i_fine_gain,
   output wire [5:0] i_coarse_gain,
   output wire [5:0] i_cm_resistor_trim,
   output wire       i_cm_resistor_enable,
   output wire [5:0] q_fine_gain,
   output wire [5:0] q_coarse_gain,
   output wire [5:0] q_cm_resistor_trim,
   output wire       q_cm_resistor_enable,
   output wire [5:0] reference_coarse_trim,
   output wire       cal_tick,
   output wire       i_cal_busy,
   output wire       q_cal_busy
);
   // ********************************************************
   // Pin synchronisers
   // ********************************************************
   reg  [2:0] sync1_reg;
   reg  [2:0] sync2_reg;
   reg        sclk_d_reg;
   wire       sclk_s;
   wire       cs_n_s;
   wire       sdi_s;
   wire       sclk_rise;
   wire       sclk_fall;

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         sync1_reg  <= 3'b010;
         sync2_reg  <= 3'b010;
         sclk_d_reg <= 1'b0;
      end
      else
      begin
         sync1_reg  <= {spi_sdi, spi_cs_n, spi_sclk};
         sync2_reg  <= sync1_reg;
         sclk_d_reg <= sync2_reg[0];
      end
   end

   assign sclk_s    = sync2_reg[0];
   assign cs_n_s    = sync2_reg[1];
   assign sdi_s     = sync2_reg[2];
   assign sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;

   // ********************************************************
   // Register storage
   // ********************************************************
   reg  [7:0] i_fine_reg;
   reg  [7:0] i_coarse_reg;
   reg  [7:0] i_cm_reg;
   reg  [7:0] q_fine_reg;
   reg  [7:0] q_coarse_reg;
   reg  [7:0] q_cm_reg;
   reg  [7:0] ref_trim_reg;
   reg  [7:0] clk_sel_reg;
   reg  [6:0] coef_addr_reg;
   reg  [5:0] coef_data_reg;
   reg  [2:0] cmd_reg;
   wire [5:0] i_rdata;
   wire [5:0] q_rdata;
   wire       i_done;
   wire       q_done;
   wire       i_uncal;
   wire       q_uncal;

   // ********************************************************
   // Serial port
   // ********************************************************
   reg  [3:0] bit_cnt_reg;
   reg  [7:0] instr_reg;
   reg  [7:0] shift_in_reg;
   reg  [7:0] shift_out_reg;
   reg        rd_phase_reg;
   reg  [7:0] read_value;
   wire [7:0] shift_next;
   wire [6:0] cur_addr;
   wire       wr_commit;

   assign shift_next = {shift_in_reg[6:0], sdi_s};
   assign cur_addr   = instr_reg[6:0];
   assign wr_commit  = sclk_rise & (bit_cnt_reg == 4'hF) & ~instr_reg[`DSC_READ_FLAG_BIT];
   assign spi_sdo_oe_n = ~rd_phase_reg;

   always @*
   begin
      read_value = 8'h00;
      case (shift_next[6:0])
         `DSC_I_FINE_GAIN   : read_value = i_fine_reg;
         `DSC_I_COARSE_GAIN : read_value = i_coarse_reg;
         `DSC_I_CM_TRIM     : read_value = i_cm_reg;
         `DSC_Q_FINE_GAIN   : read_value = q_fine_reg;
         `DSC_Q_COARSE_GAIN : read_value = q_coarse_reg;
         `DSC_Q_CM_TRIM     : read_value = q_cm_reg;
         `DSC_REF_TRIM      : read_value = ref_trim_reg;
         `DSC_CAL_CLK_SEL   : read_value = clk_sel_reg;
         `DSC_CAL_DONE_STAT : read_value = {q_done, i_done, 6'h00};
         `DSC_COEF_ADDR     : read_value = {1'b0, coef_addr_reg};
         `DSC_COEF_DATA     :
            if (cmd_reg[`DSC_RD_BIT - 2])
               read_value = {2'b00, clk_sel_reg[`DSC_I_SEL_BIT] ? i_rdata : q_rdata};
            else
               read_value = {2'b00, coef_data_reg};
         `DSC_CAL_CMD       : read_value = {3'b000, cmd_reg, i_uncal, q_uncal};
         default            : read_value = 8'h00;
      endcase
   end

   // Each transfer is one instruction byte, read flag then address, and one data byte.
   always @(posedge sys_clk)
   begin
      if (rst | cs_n_s)
      begin
         bit_cnt_reg   <= 4'h0;
         instr_reg     <= 8'h00;
         shift_in_reg  <= 8'h00;
         shift_out_reg <= 8'h00;
         rd_phase_reg  <= 1'b0;
         spi_sdo       <= 1'b0;
      end
      else
      begin
         if (sclk_rise)
         begin
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
            shift_in_reg <= shift_next;
            if (bit_cnt_reg == 4'h7)
            begin
               instr_reg     <= shift_next;
               shift_out_reg <= read_value;
               rd_phase_reg  <= shift_next[`DSC_READ_FLAG_BIT];
            end
            if (bit_cnt_reg == 4'hF)
               rd_phase_reg <= 1'b0;
         end
         if (sclk_fall & rd_phase_reg)
         begin
            spi_sdo       <= shift_out_reg[7];
            shift_out_reg <= {shift_out_reg[6:0], 1'b0};
         end
      end
   end

   // ********************************************************
   // Register writes
   // ********************************************************
   wire wr_cmd;
   wire wr_coef_data;
   assign wr_cmd       = wr_commit & (cur_addr == `DSC_CAL_CMD);
   assign wr_coef_data = wr_commit & (cur_addr == `DSC_COEF_DATA);

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         i_fine_reg    <= `DSC_REG_RESET;
         i_coarse_reg  <= `DSC_REG_RESET;
         i_cm_reg      <= `DSC_REG_RESET;
         q_fine_reg    <= `DSC_REG_RESET;
         q_coarse_reg  <= `DSC_REG_RESET;
         q_cm_reg      <= `DSC_REG_RESET;
         ref_trim_reg  <= `DSC_REG_RESET;
         clk_sel_reg   <= `DSC_REG_RESET;
         coef_addr_reg <= `DSC_COEF_FIRST;
         coef_data_reg <= 6'h00;
         cmd_reg       <= 3'b000;
      end
      else if (wr_commit)
      begin
         case (cur_addr)
            `DSC_I_FINE_GAIN   : i_fine_reg    <= shift_next;
            `DSC_I_COARSE_GAIN : i_coarse_reg  <= shift_next;
            `DSC_I_CM_TRIM     : i_cm_reg      <= shift_next;
            `DSC_Q_FINE_GAIN   : q_fine_reg    <= shift_next;
            `DSC_Q_COARSE_GAIN : q_coarse_reg  <= shift_next;
            `DSC_Q_CM_TRIM     : q_cm_reg      <= shift_next;
            `DSC_REF_TRIM      : ref_trim_reg  <= shift_next;
            `DSC_CAL_CLK_SEL   : clk_sel_reg   <= shift_next;
            `DSC_COEF_ADDR     : coef_addr_reg <= shift_next[6:0];
            `DSC_COEF_DATA     : coef_data_reg <= shift_next[5:0];
            `DSC_CAL_CMD       : cmd_reg       <= shift_next[`DSC_START_BIT:`DSC_RD_BIT];
            default            : cmd_reg       <= cmd_reg;
         endcase
      end
   end

   // ********************************************************
   // Calibration clock divider
   // ********************************************************
   // The tick is a one-cycle enable, not a real clock, so no second domain appears.
   reg  [11:0] div_cnt_reg;
   wire [11:0] div_period;
   wire        clk_en;
   wire [2:0]  div_code;

   assign clk_en     = clk_sel_reg[`DSC_CLK_EN_BIT];
   assign div_code   = clk_sel_reg[`DSC_DIV_MSB:`DSC_DIV_LSB];
   assign div_period = (PRESCALE[11:0] << 1) << div_code;
   assign cal_tick   = clk_en & (div_cnt_reg == div_period - 12'h001);

   always @(posedge sys_clk)
   begin
      if (rst | ~clk_en)
         div_cnt_reg <= 12'h000;
      else if (cal_tick)
         div_cnt_reg <= 12'h000;
      else
         div_cnt_reg <= div_cnt_reg + 12'h001;
   end

   // ********************************************************
   // Engines
   // ********************************************************
   wire       start_bit;
   wire       uncal_clear;
   wire [4:0] coef_idx;
   wire       coef_wr;
   wire [6:0] coef_off;

   assign start_bit   = cmd_reg[`DSC_START_BIT - 2] & clk_en;
   assign uncal_clear = wr_cmd & (shift_next == 8'h00);
   // Only the low five bits index the store, so out-of-range addresses wrap.
   assign coef_off    = coef_addr_reg - `DSC_COEF_FIRST;
   assign coef_idx    = coef_off[4:0];
   assign coef_wr     = wr_coef_data & cmd_reg[`DSC_WR_BIT - 2];

   dsc_cal_engine #(
      .CAL_TICKS (CAL_TICKS)
   ) u_i_engine (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .cal_tick    (cal_tick),
      .start_level (start_bit & clk_sel_reg[`DSC_I_SEL_BIT]),
      .uncal_clear (uncal_clear),
      .measure     (i_measure),
      .host_idx    (coef_idx),
      .host_we     (coef_wr & clk_sel_reg[`DSC_I_SEL_BIT]),
      .host_wdata  (shift_next[5:0]),
      .host_rdata  (i_rdata),
      .done_reg    (i_done),
      .uncal_reg   (i_uncal),
      .busy_reg    (i_cal_busy)
   );

   dsc_cal_engine #(
      .CAL_TICKS (CAL_TICKS)
   ) u_q_engine (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .cal_tick    (cal_tick),
      .start_level (start_bit & clk_sel_reg[`DSC_Q_SEL_BIT]),
      .uncal_clear (uncal_clear),
      .measure     (q_measure),
      .host_idx    (coef_idx),
      .host_we     (coef_wr & clk_sel_reg[`DSC_Q_SEL_BIT]),
      .host_wdata  (shift_next[5:0]),
      .host_rdata  (q_rdata),
      .done_reg    (q_done),
      .uncal_reg   (q_uncal),
      .busy_reg    (q_cal_busy)
   );

   // ********************************************************
   // Trim outputs
   // ********************************************************
   assign i_fine_gain           = i_fine_reg[5:0];
   assign i_coarse_gain         = i_coarse_reg[5:0];
   assign i_cm_resistor_trim    = i_cm_reg[5:0];
   assign i_cm_resistor_enable  = i_cm_reg[`DSC_CM_EN_BIT];
   assign q_fine_gain           = q_fine_reg[5:0];
   assign q_coarse_gain         = q_coarse_reg[5:0];
   assign q_cm_resistor_trim    = q_cm_reg[5:0];
   assign q_cm_resistor_enable  = q_cm_reg[`DSC_CM_EN_BIT];
   assign reference_coarse_trim = ref_trim_reg[5:0];
endmodule // dsc_cal_trim

// ---- verification/dsc_cal_trim_checker.sv ----
// Port-level checker for the calibration and trim block.
`timescale 1ns/1ps
// ****************
// Checker
// ****************
module dsc_cal_trim_checker #(
   parameter CAL_TICKS = 300
) (
   input wire       sys_clk,
   input wire       rst,
   input wire       spi_cs_n,
   input wire       spi_sdo,
   input wire       spi_sdo_oe_n,
   input wire [5:0] i_fine_gain,
   input wire [5:0] i_coarse_gain,
   input wire [5:0] q_fine_gain,
   input wire [5:0] reference_coarse_trim,
   input wire       i_cm_resistor_enable,
   input wire       cal_tick,
   input wire       i_cal_busy,
   input wire       q_cal_busy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Gap saturates so a long stop of the tick never wraps into a false short period.
   reg [11:0] gap_reg;
   reg        seen_reg;
   reg [15:0] cnt_reg;
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         gap_reg  <= 12'h000;
         seen_reg <= 1'b0;
         cnt_reg  <= 16'h0000;
      end
      else
      begin
         gap_reg  <= cal_tick ? 12'h000 : gap_reg + {11'h000, gap_reg != 12'hfff};
         seen_reg <= seen_reg | cal_tick;
         cnt_reg  <= i_cal_busy ? cnt_reg + {15'h0000, cal_tick} : 16'h0000;
      end
   end
   a_tick_one_cycle: assert property (cal_tick |=> !cal_tick)
      else $error("calibration tick longer than one cycle");
   a_tick_min_spacing: assert property (cal_tick && seen_reg |-> gap_reg >= 12'h01f)
      else $error("calibration ticks closer than 32 cycles");
   a_cal_tick_bound: assert property (cnt_reg <= CAL_TICKS)
      else $error("calibration ran past its tick count");
   a_finish_count: assert property ($fell(i_cal_busy) && $past(spi_cs_n) && $past(spi_cs_n, 4)
      |-> cnt_reg == CAL_TICKS)
      else $error("calibration ended after a wrong tick count");
   a_busy_by_write: assert property ($rose(i_cal_busy) || $rose(q_cal_busy)
      |-> !$past(spi_cs_n))
      else $error("calibration started outside a port write");
   a_idle_port_quiet: assert property (spi_cs_n [*8] |-> spi_sdo_oe_n && !spi_sdo)
      else $error("serial output driven while deselected");
   a_trims_frozen: assert property (spi_cs_n [*8] |-> $stable(i_fine_gain)
      && $stable(i_coarse_gain) && $stable(q_fine_gain) && $stable(reference_coarse_trim))
      else $error("trim output changed without a port transfer");
   a_reset_state: assert property (disable iff (1'b0) rst |=> i_fine_gain == 6'h00
      && !i_cm_resistor_enable && !i_cal_busy && !q_cal_busy && spi_sdo_oe_n)
      else $error("outputs not at their reset values");
endmodule // dsc_cal_trim_checker

bind dsc_cal_trim dsc_cal_trim_checker #(.CAL_TICKS(CAL_TICKS)) chk_u (.sys_clk, .rst,
   .spi_cs_n, .spi_sdo, .spi_sdo_oe_n, .i_fine_gain, .i_coarse_gain, .q_fine_gain,
   .reference_coarse_trim, .i_cm_resistor_enable, .cal_tick, .i_cal_busy, .q_cal_busy);

// ---- verification/dsc_spi_host.sv ----
// Host model that runs 16-bit frames on the serial register port.
`timescale 1ns/1ps
// ****************
// Serial host
// ****************
module dsc_spi_host #(
   parameter HALF = 6
) (
   input  wire sys_clk,
   output reg  spi_sclk,
   output reg  spi_cs_n,
   output reg  spi_sdi,
   input  wire spi_sdo
);
   initial
   begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi  = 1'b0;
   end
   // Clock idles low and data moves while it is low; each level lasts HALF cycles.
   task xfer(input [15:0] f, output [7:0] rd);
      integer i;
      begin
         rd = 8'h00;
         @(posedge sys_clk);
         spi_cs_n <= 1'b0;
         for (i = 15; i >= 0; i = i - 1)
         begin
            spi_sdi <= f[i];
            repeat (HALF) @(posedge sys_clk);
            rd = {rd[6:0], spi_sdo};
            spi_sclk <= 1'b1;
            repeat (HALF) @(posedge sys_clk);
            spi_sclk <= 1'b0;
         end
         repeat (HALF) @(posedge sys_clk);
         spi_cs_n <= 1'b1;
         // A deselected data line must not keep showing the last bit.
         spi_sdi  <= ~f[0];
         repeat (HALF) @(posedge sys_clk);
      end
   endtask
endmodule // dsc_spi_host

// ---- verification/tb_top.sv ----
// Self-checking bench for the calibration and trim block.
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module tb_top;
   localparam CAL = 40;
   reg        sys_clk     = 1'b0;
   reg        rst         = 1'b1;
   reg  [5:0] i_measure   = 6'h00;
   reg  [5:0] q_measure   = 6'h00;
   wire       spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
   wire       cal_tick, i_cal_busy, q_cal_busy, i_cm_resistor_enable, q_cm_resistor_enable;
   wire [5:0] i_fine_gain, i_coarse_gain, i_cm_resistor_trim, reference_coarse_trim;
   wire [5:0] q_fine_gain, q_coarse_gain, q_cm_resistor_trim;
   integer    err_count   = 0;
   integer    comparisons = 0;
   integer    seed        = 88159;
   integer    oe_cnt      = 0;
   integer    k, d, n, p;
   reg  [7:0] r;
   reg  [7:0] tv [0:6];
   reg  [5:0] cv [0:7];
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
      if (spi_sdo_oe_n === 1'b0)
         oe_cnt <= oe_cnt + 1;
   dsc_cal_trim #(.CAL_TICKS(CAL)) dut_u (.sys_clk, .rst, .spi_sclk, .spi_cs_n, .spi_sdi,
      .spi_sdo, .spi_sdo_oe_n, .i_measure, .q_measure, .i_fine_gain, .i_coarse_gain,
      .i_cm_resistor_trim, .i_cm_resistor_enable, .q_fine_gain, .q_coarse_gain,
      .q_cm_resistor_trim, .q_cm_resistor_enable, .reference_coarse_trim, .cal_tick,
      .i_cal_busy, .q_cal_busy);
   dsc_spi_host host_u (.sys_clk, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo);
   function [6:0] ka(input integer i);
      ka = (i < 6) ? i + 3 : 7'h0d;
   endfunction
   function [6:0] ca(input integer i);
      ca = (i < 3) ? i * 8 + 1 : 7'h20;
   endfunction
   task check(input string nm, input [63:0] seen, input [63:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp)
         begin
            err_count = err_count + 1;
            $display("unexpected %0s: expected %h, seen %h", nm, exp, seen);
         end
      end
   endtask
   task print_verdict;
      begin
         if (err_count == 0 && comparisons > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task wr(input [6:0] a, input [7:0] v);
      host_u.xfer({1'b0, a, v}, r);
   endtask
   task rd(input [6:0] a);
      host_u.xfer({1'b1, a, 8'h00}, r);
   endtask
   // Bounded wait; returns the cycles up to and including the next tick.
   task wait_tick(output integer c);
      begin
         c = 1;
         @(negedge sys_clk);
         while (cal_tick !== 1'b1 && c < 5000)
         begin
            @(negedge sys_clk);
            c = c + 1;
         end
         if (c >= 5000)
         begin
            err_count = err_count + 1;
            print_verdict;
         end
      end
   endtask
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (k = 3; k < 19; k = k + 1)
      begin
         if (k < 9 || k > 12)
         begin
            rd(k[6:0]);
            check("reset value", r, (k == 16) ? 1 : (k == 18) ? 3 : 0);
         end
      end
      for (k = 0; k < 7; k = k + 1)
      begin
         tv[k] = $random(seed);
         wr(ka(k), tv[k]);
         rd(ka(k));
         check("trim readback", r, tv[k]);
      end
      check("trim outputs", {i_fine_gain, i_coarse_gain, i_cm_resistor_trim, q_fine_gain,
         q_coarse_gain, q_cm_resistor_trim, reference_coarse_trim, i_cm_resistor_enable,
         q_cm_resistor_enable}, {tv[0][5:0], tv[1][5:0], tv[2][5:0], tv[3][5:0], tv[4][5:0],
         tv[5][5:0], tv[6][5:0], tv[2][6], tv[5][6]});
      wr(7'h09, 8'h5a);
      p = oe_cnt;
      rd(7'h09);
      check("unmapped", r, 0);
      check("read enable cycles", oe_cnt - p, 96);
      for (d = 0; d < 2; d = d + 1)
      begin
         wr(7'h0e, d ? 8'h20 : 8'h10);
         wr(7'h12, 8'h08);
         for (k = 0; k < 4; k = k + 1)
         begin
            cv[d * 4 + k] = $random(seed);
            wr(7'h10, {1'b0, ca(k)});
            wr(7'h11, {2'b00, cv[d * 4 + k]});
         end
         wr(7'h12, 8'h00);
      end
      for (d = 0; d < 2; d = d + 1)
      begin
         wr(7'h0e, d ? 8'h20 : 8'h10);
         for (k = 0; k < 4; k = k + 1)
         begin
            wr(7'h10, {1'b0, ca(k)});
            wr(7'h12, 8'h04);
            rd(7'h11);
            check("coefficient", r, {2'b00, cv[d * 4 + k]});
            wr(7'h12, 8'h00);
         end
      end
      for (k = 0; k < 8; k = k + 1)
      begin
         wr(7'h0e, 8'h08 | k[7:0]);
         wait_tick(p);
         wait_tick(p);
         check("tick period", p, 32 << k);
      end
      wr(7'h0e, 8'h00);
      n = 0;
      repeat (300)
      begin
         @(negedge sys_clk);
         if (cal_tick === 1'b1)
            n = n + 1;
      end
      check("stopped ticks", n, 0);
      wr(7'h12, 8'h00);
      i_measure <= $random(seed);
      q_measure <= $random(seed);
      rd(7'h12);
      check("flags cleared", r, 0);
      wr(7'h0e, 8'h38);
      wr(7'h12, 8'h10);
      check("both busy", {i_cal_busy, q_cal_busy}, 2'b11);
      n = 0;
      while ((i_cal_busy !== 1'b0 || q_cal_busy !== 1'b0) && n < CAL * 32 + 500)
      begin
         @(negedge sys_clk);
         n = n + 1;
      end
      check("calibration length", n > (CAL - 2) * 32 && n < CAL * 32 + 500, 1);
      rd(7'h0f);
      check("done flags", r, 8'hc0);
      rd(7'h12);
      check("command", r, 8'h10);
      wr(7'h12, 8'h00);
      wr(7'h0e, 8'h10);
      wr(7'h10, 8'h01);
      wr(7'h12, 8'h04);
      rd(7'h11);
      check("i captured", r, {2'b00, i_measure});
      wr(7'h0e, 8'h20);
      rd(7'h11);
      check("q captured", r, {2'b00, q_measure});
      wr(7'h12, 8'h00);
      wr(7'h0e, 8'h18);
      wr(7'h12, 8'h10);
      repeat (100) @(posedge sys_clk);
      check("i only busy", {i_cal_busy, q_cal_busy}, 2'b10);
      wr(7'h12, 8'h00);
      rd(7'h12);
      check("abort flag", r, 8'h02);
      rd(7'h0f);
      check("done after abort", r, 8'h80);
      wr(7'h12, 8'h00);
      rd(7'h12);
      check("flags cleared", r, 0);
      wr(7'h0e, 8'h00);
      print_verdict;
   end
endmodule // tb_top
